/* File: design/brake_pkg.sv */
// constants, register map and types shared by the brake control block
package brake_pkg;

    // ------------------------------------------------------------------
    // bus and channel widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int CHANNELS = 4;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_PWM_CONTROL = 8'hDC;
    localparam logic [7:0] IDX_BRAKE_CONTROL = 8'hDF;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'hE8;
    localparam logic [7:0] IDX_BRAKE_STATUS = 8'hE9;
    localparam logic [ADDR_W-1:0] ADDR_PWM_CONTROL = {2'h0, IDX_PWM_CONTROL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_BRAKE_CONTROL = {2'h0, IDX_BRAKE_CONTROL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = {2'h0, IDX_IRQ_ENABLE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_BRAKE_STATUS = {2'h0, IDX_BRAKE_STATUS, 2'h0};

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_MODE_LOW = 7;
    localparam int BIT_PIN_POLARITY = 6;
    localparam int BIT_MODE_PIN = 5;
    localparam int BIT_BRAKE_ENABLE = 4;
    localparam int BIT_LEVEL_LSB = 0;
    localparam int BIT_COUNTER_RUN = 7;
    localparam int BIT_INVERT_LSB = 0;
    localparam int BIT_IRQ_ENABLE = 5;
    localparam int BIT_FLAG = 0;
    localparam int BIT_PIN_ASSERTED = 1;
    localparam int BIT_BRAKE_ACTIVE = 2;
    localparam int BIT_PIN_LATCHED = 3;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [REG_W-1:0] RST_BRAKE_CONTROL = 8'h00;
    localparam logic [CHANNELS-1:0] RST_INVERT = 4'h0;
    localparam logic RST_COUNTER_RUN = 1'b0;
    localparam logic RST_IRQ_ENABLE = 1'b0;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    // brake mode, coded {pin select, low select}
    typedef enum logic [1:0] {
        MODE_SOFT = 2'b00,
        MODE_STOPPED = 2'b01,
        MODE_PIN = 2'b10,
        MODE_NONE = 2'b11
    } brake_mode_t;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_SOFT = 3'b001,
        ST_STOPPED = 3'b010,
        ST_PIN = 3'b011,
        ST_RESUME = 3'b100
    } brake_state_t;

endpackage

/* File: design/brake_stage_if.sv */
// carrier between the brake controller and its output stage
`timescale 1ns/1ps
interface brake_stage_if;
    logic force_brake;
    logic hold_snap;
    logic capture;
    logic [3:0] level;
    logic [3:0] invert;
    logic [3:0] gen;

    modport ctrl (output force_brake, output hold_snap, output capture, output level, output invert, output gen);
    modport stage (input force_brake, input hold_snap, input capture, input level, input invert, input gen);
endinterface

/* File: design/brake_output_stage.sv */
// per-channel output stage: brake level, snapshot hold or inverted generator
`timescale 1ns/1ps
module brake_output_stage (
    input wire logic sys_clk,
    input wire logic rst_sync_b,
    brake_stage_if.stage st,
    output logic [brake_pkg::CHANNELS-1:0] pwm_out
);
    import brake_pkg::*;

    typedef struct packed {
        logic [CHANNELS-1:0] snap;
        logic [CHANNELS-1:0] out;
    } stage_state_t;

    stage_state_t cur_q;
    stage_state_t nxt_d;
    logic [CHANNELS-1:0] out_bit;

    // ------------------------------------------------------------------
    // per-channel selection
    // ------------------------------------------------------------------
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        // brake level goes out raw, inversion never touches it
        assign out_bit[ch] = st.force_brake ? st.level[ch] : // R3 R13
            (st.hold_snap ? (cur_q.snap[ch] ^ st.invert[ch]) : (st.gen[ch] ^ st.invert[ch])); // R7 R9
    end

    // next state
    always_comb begin
        nxt_d = cur_q;
        if (st.capture) begin
            nxt_d.snap = st.gen; // generator level just before the brake
        end
        nxt_d.out = out_bit;
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cur_q <= '0;
        end else begin
            cur_q <= nxt_d;
        end
    end

    assign pwm_out = cur_q.out;
endmodule

/* File: design/pwm_brake_control.sv */
// brake control for a four-channel pwm unit with an apb register slave
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// R1 - brake input counts as asserted low when polarity 0, high when polarity 1
// R2 - brake enable 0 means no brake in any mode; a latched pin brake still holds with enable 0 until the pin is released
// R3 - during a brake each output shows its own brake level bit
// R4 - mode 00 brakes at once, counter keeps running
// R5 - leaving software brake, outputs follow the live generator
// R6 - mode 01 brakes only while the counter is stopped
// R7 - clearing enable in mode 01 restores the generator level held at stop
// R8 - mode 10 with pin asserted forces levels, stops counter, sets flag
// R9 - pin brake ends only when pin released and enable cleared
// R10 - mode 11 applies no brake at all
// R11 - counter run bit shows and controls whether the counter runs
// R12 - brake interrupt request only when its enable bit is set
// R13 - brake levels go to pins without channel inversion
module pwm_brake_control (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [brake_pkg::ADDR_W-1:0] paddr,
    input wire logic [brake_pkg::DATA_W-1:0] pwdata,
    output logic [brake_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic brake_input_pin,
    input wire logic [brake_pkg::CHANNELS-1:0] pwm_gen,
    output logic counter_run,
    output logic brake_irq,
    output logic [brake_pkg::CHANNELS-1:0] pwm_out
);
    import brake_pkg::*;

    typedef struct packed {
        logic [REG_W-1:0] brake_control;
        logic [CHANNELS-1:0] invert;
        logic counter_run;
        logic brake_irq_enable;
        logic external_brake_flag;
        logic irq;
        brake_state_t state;
        logic [DATA_W-1:0] rdata;
        logic ready;
        logic slverr;
    } ctrl_state_t;

    ctrl_state_t cur_q;
    ctrl_state_t nxt_d;
    logic [1:0] rst_pipe_q;
    logic rst_sync_b;
    brake_stage_if stage_bus ();

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    // asserts at once, releases two edges later to keep release glitch free
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe_q <= 2'b00;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_sync_b = rst_pipe_q[1];

    // ------------------------------------------------------------------
    // decoded control fields
    // ------------------------------------------------------------------
    brake_mode_t mode;
    logic enable;
    logic pin_asserted;
    logic setup_phase;
    logic access_done;
    logic wr_done;
    logic addr_hit;

    assign mode = brake_mode_t'({cur_q.brake_control[BIT_MODE_PIN], cur_q.brake_control[BIT_MODE_LOW]});
    assign enable = cur_q.brake_control[BIT_BRAKE_ENABLE];
    // polarity 1 means active high, 0 means active low
    assign pin_asserted = cur_q.brake_control[BIT_PIN_POLARITY] ? brake_input_pin : ~brake_input_pin; // R1
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & cur_q.ready;
    assign wr_done = access_done & pwrite & ~cur_q.slverr;
    assign addr_hit = (paddr == ADDR_PWM_CONTROL) | (paddr == ADDR_BRAKE_CONTROL) |
        (paddr == ADDR_IRQ_ENABLE) | (paddr == ADDR_BRAKE_STATUS);

    // ------------------------------------------------------------------
    // register file, brake sequencer and bus answer
    // ------------------------------------------------------------------
    always_comb begin
        nxt_d = cur_q;

        // apb: answer in the first access cycle, data taken at setup
        nxt_d.ready = setup_phase;
        nxt_d.slverr = setup_phase & ~addr_hit;
        if (setup_phase) begin
            nxt_d.rdata = '0;
            unique case (paddr)
                ADDR_PWM_CONTROL: begin
                    nxt_d.rdata[BIT_COUNTER_RUN] = cur_q.counter_run; // R11
                    nxt_d.rdata[BIT_INVERT_LSB +: CHANNELS] = cur_q.invert;
                end
                ADDR_BRAKE_CONTROL: begin
                    nxt_d.rdata[REG_W-1:0] = cur_q.brake_control;
                end
                ADDR_IRQ_ENABLE: begin
                    nxt_d.rdata[BIT_IRQ_ENABLE] = cur_q.brake_irq_enable;
                end
                ADDR_BRAKE_STATUS: begin
                    nxt_d.rdata[BIT_FLAG] = cur_q.external_brake_flag;
                    nxt_d.rdata[BIT_PIN_ASSERTED] = pin_asserted;
                    nxt_d.rdata[BIT_BRAKE_ACTIVE] = (cur_q.state != ST_RUN) && (cur_q.state != ST_RESUME);
                    nxt_d.rdata[BIT_PIN_LATCHED] = (cur_q.state == ST_PIN);
                end
                default: begin
                    nxt_d.rdata = '0;
                end
            endcase
        end

        // software writes take effect at the completing edge
        if (wr_done) begin
            unique case (paddr)
                ADDR_PWM_CONTROL: begin
                    nxt_d.counter_run = pwdata[BIT_COUNTER_RUN]; // R11
                    nxt_d.invert = pwdata[BIT_INVERT_LSB +: CHANNELS];
                end
                ADDR_BRAKE_CONTROL: begin
                    nxt_d.brake_control = pwdata[REG_W-1:0];
                end
                ADDR_IRQ_ENABLE: begin
                    nxt_d.brake_irq_enable = pwdata[BIT_IRQ_ENABLE];
                end
                ADDR_BRAKE_STATUS: begin
                    // write one to clear
                    if (pwdata[BIT_FLAG]) begin
                        nxt_d.external_brake_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // brake sequencer
        unique case (cur_q.state)
            ST_RUN: begin
                if (enable) begin // R2
                    unique case (mode)
                        MODE_SOFT: begin
                            nxt_d.state = ST_SOFT; // R4
                        end
                        MODE_STOPPED: begin
                            if (!cur_q.counter_run) begin
                                nxt_d.state = ST_STOPPED; // R6
                            end
                        end
                        MODE_PIN: begin
                            if (pin_asserted) begin
                                nxt_d.state = ST_PIN; // R8
                            end
                        end
                        MODE_NONE: begin
                            nxt_d.state = ST_RUN; // R10
                        end
                    endcase
                end
            end
            ST_SOFT: begin
                // straight back to the live generator, no snapshot
                if (!enable || mode != MODE_SOFT) begin
                    nxt_d.state = ST_RUN; // R5
                end
            end
            ST_STOPPED: begin
                if (!enable) begin
                    nxt_d.state = ST_RESUME; // R7
                end else if (cur_q.counter_run || mode != MODE_STOPPED) begin
                    nxt_d.state = ST_RUN; // R6
                end
            end
            ST_PIN: begin
                // latched: needs both pin release and enable cleared
                if (!enable && !pin_asserted) begin
                    nxt_d.state = ST_RESUME; // R9
                end
            end
            ST_RESUME: begin
                // hold pre-brake level until the counter is restarted or enable is set again
                if (cur_q.counter_run) begin
                    nxt_d.state = ST_RUN;
                end else if (enable) begin
                    nxt_d.state = ST_RUN;
                end
            end
            default: begin
                nxt_d.state = ST_RUN;
            end
        endcase

        // pin brake stops the counter; hardware beats a software start
        if (enable && mode == MODE_PIN && pin_asserted) begin
            nxt_d.counter_run = 1'b0; // R8
            nxt_d.external_brake_flag = 1'b1; // R8
        end

        // brake request leaves as a registered level
        nxt_d.irq = nxt_d.external_brake_flag & nxt_d.brake_irq_enable; // R12
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cur_q.brake_control <= RST_BRAKE_CONTROL;
            cur_q.invert <= RST_INVERT;
            cur_q.counter_run <= RST_COUNTER_RUN;
            cur_q.brake_irq_enable <= RST_IRQ_ENABLE;
            cur_q.external_brake_flag <= 1'b0;
            cur_q.irq <= 1'b0;
            cur_q.state <= ST_RUN;
            cur_q.rdata <= '0;
            cur_q.ready <= 1'b0;
            cur_q.slverr <= 1'b0;
        end else begin
            cur_q <= nxt_d;
        end
    end

    // ------------------------------------------------------------------
    // output stage control
    // ------------------------------------------------------------------
    // outputs lag the sequencer by one edge through the stage register
    assign stage_bus.force_brake = (cur_q.state == ST_SOFT) || (cur_q.state == ST_STOPPED) ||
        (cur_q.state == ST_PIN); // R3
    assign stage_bus.hold_snap = (cur_q.state == ST_RESUME); // R7 R9
    assign stage_bus.capture = (cur_q.state == ST_RUN) &&
        ((nxt_d.state == ST_STOPPED) || (nxt_d.state == ST_PIN));
    assign stage_bus.level = cur_q.brake_control[BIT_LEVEL_LSB +: CHANNELS];
    assign stage_bus.invert = cur_q.invert;
    assign stage_bus.gen = pwm_gen;

    brake_output_stage u_stage (
        .sys_clk(sys_clk),
        .rst_sync_b(rst_sync_b),
        .st(stage_bus),
        .pwm_out(pwm_out)
    );

    assign prdata = cur_q.rdata;
    assign pready = cur_q.ready;
    assign pslverr = cur_q.slverr;
    assign counter_run = cur_q.counter_run;
    assign brake_irq = cur_q.irq;
endmodule

/* File: tb/brake_pin_model.sv */
// far-side model: brake pin driver and pwm generator source
`timescale 1ns/1ps
module brake_pin_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic counter_run,
    input wire logic pin_active,
    input wire logic polarity,
    output logic brake_input_pin,
    output logic [3:0] pwm_gen
);
    // generator steps only while the counter runs, so a stop freezes it
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pwm_gen <= 4'h0;
        end else if (counter_run) begin
            pwm_gen <= pwm_gen + 4'h3;
        end
    end
    // inactive level is the inverse of the asserting one
    assign brake_input_pin = pin_active ? polarity : ~polarity;
endmodule

/* File: tb/pwm_brake_control_asserts.sv */
// concurrent checks on the brake control ports
`timescale 1ns/1ps
module pwm_brake_control_asserts import brake_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic brake_input_pin,
    input wire logic [CHANNELS-1:0] pwm_gen,
    input wire logic counter_run,
    input wire logic brake_irq,
    input wire logic [CHANNELS-1:0] pwm_out
);
    logic [7:0] ctl_q;
    logic [3:0] inv_q;
    logic irqen_q;
    wire wr_done = psel && penable && pready && pwrite;
    wire mapped = paddr == ADDR_PWM_CONTROL || paddr == ADDR_BRAKE_CONTROL
        || paddr == ADDR_IRQ_ENABLE || paddr == ADDR_BRAKE_STATUS;
    wire en = ctl_q[BIT_BRAKE_ENABLE];
    wire [1:0] mode = {ctl_q[BIT_MODE_PIN], ctl_q[BIT_MODE_LOW]};
    wire pin_on = brake_input_pin == ctl_q[BIT_PIN_POLARITY];
    wire [3:0] live = pwm_gen ^ inv_q;
    wire run_bit = pwdata[BIT_COUNTER_RUN];
    // shadow copies of the registers, taken at write completion
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_q <= RST_BRAKE_CONTROL;
            inv_q <= RST_INVERT;
            irqen_q <= RST_IRQ_ENABLE;
        end else if (wr_done) begin
            if (paddr == ADDR_BRAKE_CONTROL) ctl_q <= pwdata[7:0];
            if (paddr == ADDR_PWM_CONTROL) inv_q <= pwdata[3:0];
            if (paddr == ADDR_IRQ_ENABLE) irqen_q <= pwdata[BIT_IRQ_ENABLE];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // three cycles lets the state register and the output register settle
    sequence held(logic [1:0] m, logic c);
        (en && mode == m && c) [*3];
    endsequence
    apb_answer_a: assert property (psel && !penable |=> pready && pslverr == !mapped) else $error("apb answer wrong");
    pready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
    soft_level_a: assert property (held(2'b00, 1'b1) |-> pwm_out == ctl_q[3:0]) else $error("soft level");
    none_live_a: assert property (held(2'b11, 1'b1) |-> pwm_out == $past(live)) else $error("mode 11 braked");
    stop_live_a: assert property (held(2'b01, counter_run) |-> pwm_out == $past(live)) else $error("stop live");
    stop_level_a: assert property (held(2'b01, !counter_run) |-> pwm_out == ctl_q[3:0]) else $error("stop level");
    pin_stop_a: assert property (en && mode == 2'b10 && pin_on |=> !counter_run) else $error("pin no stop");
    pin_irq_a: assert property (en && mode == 2'b10 && pin_on && irqen_q |=> brake_irq) else $error("no irq");
    pin_hold_a: assert property (held(2'b10, pin_on) |-> pwm_out == ctl_q[3:0]) else $error("pin level");
    irq_mask_a: assert property (!irqen_q ##1 !irqen_q |-> !brake_irq) else $error("masked irq seen");
    run_write_a: assert property (wr_done && paddr == ADDR_PWM_CONTROL && mode != 2'b10
        |=> counter_run == $past(run_bit)) else $error("run bit write lost");
endmodule
bind pwm_brake_control pwm_brake_control_asserts u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .brake_input_pin(brake_input_pin), .pwm_gen(pwm_gen), .counter_run(counter_run), .brake_irq(brake_irq),
    .pwm_out(pwm_out));

/* File: tb/pwm_brake_control_tb.sv */
// register-level testbench for the brake control block
`timescale 1ns/1ps
module pwm_brake_control_tb;
    import brake_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr, brake_input_pin, counter_run, brake_irq;
    logic [CHANNELS-1:0] pwm_gen, pwm_out, snap;
    logic pin_act = 1'b0;
    logic pol = 1'b1;
    logic err_seen;
    logic [31:0] rd;
    int n_mismatch = 0;
    int total_checks = 0;
    always #5 sys_clk = ~sys_clk;
    pwm_brake_control u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .brake_input_pin(brake_input_pin), .pwm_gen(pwm_gen), .counter_run(counter_run),
        .brake_irq(brake_irq), .pwm_out(pwm_out));
    brake_pin_model u_far (.sys_clk(sys_clk), .rst_b(rst_b), .counter_run(counter_run), .pin_active(pin_act),
        .polarity(pol), .brake_input_pin(brake_input_pin), .pwm_gen(pwm_gen));
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer; an idle cycle follows so psel never toggles twice at one edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) n_mismatch++;
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        idle(20);
        rst_b <= 1'b1;
        idle(3);
        xfer(0, ADDR_BRAKE_CONTROL, 0);
        chk("ctl reset", 32'h0, rd);
        xfer(0, ADDR_PWM_CONTROL, 0);
        chk("pwmc reset", 32'h0, rd);
        chk("out reset", 32'h0, pwm_out);
        xfer(0, 12'h000, 0);
        chk("unmapped err", 32'h1, err_seen);
        xfer(1, ADDR_PWM_CONTROL, 32'h85);
        xfer(0, ADDR_PWM_CONTROL, 0);
        chk("run set", 32'h85, rd);
        xfer(1, ADDR_BRAKE_CONTROL, 32'hBA);
        idle(3);
        chk("mode11 run", 32'h1, counter_run);
        xfer(1, ADDR_BRAKE_CONTROL, 32'h1A);
        idle(3);
        chk("soft level", 32'hA, pwm_out);
        chk("soft run", 32'h1, counter_run);
        // release with the counter running: output must pick up the live generator at once
        xfer(1, ADDR_BRAKE_CONTROL, 32'h0A);
        idle(3);
        snap = pwm_gen;
        idle(1);
        chk("soft release", {28'h0, snap ^ 4'h5}, pwm_out);
        // brake disabled: no mode may stop the counter, even with the pin asserted
        pin_act <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            xfer(1, ADDR_BRAKE_CONTROL, {24'h0, m[0], 1'b1, m[1], 5'h0F});
            idle(3);
            chk("off run", 32'h1, counter_run);
        end
        pin_act <= 1'b0;
        xfer(1, ADDR_BRAKE_CONTROL, 32'h9C);
        idle(3);
        xfer(1, ADDR_PWM_CONTROL, 32'h05);
        idle(3);
        chk("stop level", 32'hC, pwm_out);
        snap = pwm_gen;
        xfer(1, ADDR_BRAKE_CONTROL, 32'h8C);
        idle(3);
        chk("stop resume", {28'h0, snap ^ 4'h5}, pwm_out);
        // pin brake for both polarities, interrupt enabled only with polarity 1
        for (int p = 1; p >= 0; p--) begin
            pol <= p[0];
            xfer(1, ADDR_PWM_CONTROL, 32'h85);
            xfer(1, ADDR_IRQ_ENABLE, p[0] ? 32'h20 : 32'h0);
            xfer(1, ADDR_BRAKE_CONTROL, {24'h0, 1'b0, p[0], 1'b1, 5'h13});
            idle(3);
            chk("pin idle run", 32'h1, counter_run);
            pin_act <= 1'b1;
            // generator value seen by the brake entry edge is the one to come back later
            idle(1);
            snap = pwm_gen;
            idle(2);
            chk("pin stop", 32'h0, counter_run);
            chk("pin irq", {31'h0, p[0]}, brake_irq);
            chk("pin level", 32'h3, pwm_out);
            xfer(0, ADDR_BRAKE_STATUS, 0);
            chk("flag set", 32'hF, rd);
            xfer(1, ADDR_PWM_CONTROL, 32'h85);
            xfer(0, ADDR_PWM_CONTROL, 0);
            chk("run refused", 32'h05, rd);
            xfer(1, ADDR_BRAKE_CONTROL, {24'h0, 1'b0, p[0], 1'b1, 5'h03});
            idle(3);
            chk("pin still held", 32'h3, pwm_out);
            pin_act <= 1'b0;
            xfer(1, ADDR_BRAKE_STATUS, 32'h1);
            xfer(0, ADDR_BRAKE_STATUS, 0);
            chk("flag clear", 32'h0, rd);
            chk("irq clear", 32'h0, brake_irq);
            chk("pin resume", {28'h0, snap ^ 4'h5}, pwm_out);
        end
        close_out();
    end
    // watchdog sized well above the fewer than two hundred cycles the tests need
    initial begin
        idle(5000);
        n_mismatch++;
        close_out();
    end
endmodule
